/* File: logic/cbc_map.svh */
`ifndef CBC_MAP_SVH
`define CBC_MAP_SVH
// register byte addresses
`define CBC_OFS_SKT_CTRL 8'h10
`define CBC_OFS_PWR_MGMT 8'h20
`define CBC_OFS_IRQ_STAT 8'h30
`define CBC_OFS_IRQ_MASK 8'h34
// socket control fields
`define CBC_SC_VPP_LO 0
`define CBC_SC_VCC_LO 4
`define CBC_SC_STOP_BIT 7
// power management fields
`define CBC_PM_SEL_BIT 0
`define CBC_PM_EN_BIT 16
`define CBC_PM_SLOW_BIT 24
`define CBC_PM_ACC_BIT 25
// supply codes
`define CBC_SUP_OFF 3'h0
`define CBC_VPP_12V0 3'h1
`define CBC_SUP_5V0 3'h2
`define CBC_SUP_3V3 3'h3
`define CBC_SUP_XV 3'h4
`define CBC_SUP_YV 3'h5
// timing
`define CBC_IDLE_CLKS 4'h8
`define CBC_DIV_LAST 4'hf
`define CBC_RESET_WORD 32'h0000_0000
`endif

/* File: logic/cbc_pkg.sv */
package cbc_pkg;
	typedef enum logic [1:0] {CLK_RUN, CLK_STOPPED, CLK_SLOWED} cbc_clk_e;
	typedef logic [2:0] cbc_supply_t;
endpackage

/* File: logic/cbc_socket_clock_power.sv */
// Overview of operation
// - policy 0: stop card clock after 8 idle clocks and a host stop request.
// - policy 1: stop card clock after 8 idle clocks, host request ignored.
// - card supply field bits 6:4; only off, 5.0, 3.3, X, Y are valid.
// - program supply field bits 2:0; off, 12, 5.0, 3.3, X, Y are valid.
// - supply fields cleared by global reset; also bus reset when events disabled.
// - reserved bits of both registers read as zero.
// - access flag bit 25 set on card access, cleared by power register read.
// - bit 24 reads 1 while card clock is changed, else 0.
// - bit 16 enables idle clock control, resets to 0.
// - with control on and idle, bit 0 selects stop (0) or divide by 16 (1).
// - socket powered only when request fits the detected card type.
`timescale 1ns/1ps
`include "cbc_map.svh"
module cbc_socket_clock_power (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic pci_bus_reset_n,
	input wire logic pmeEnable,
	input wire logic [7:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	input wire logic cardBusy,
	input wire logic cardAccess,
	input wire logic pciStopRequest,
	input wire logic card5vOk,
	input wire logic card3vOk,
	input wire logic cardXvOk,
	input wire logic cardYvOk,
	output logic cardClockEnable,
	output logic [2:0] cardSupplyApplied,
	output logic [2:0] programSupplyApplied,
	output logic irq
);
	// =====================================
	// reset and input synchronisers
	logic [1:0] rstSync_q;
	logic rstN;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) rstSync_q <= 2'h0;
		else rstSync_q <= {rstSync_q[0], 1'h1};
	end
	assign rstN = rstSync_q[1];

	logic [1:0] prstSync_q;
	logic [1:0] pmeSync_q;
	logic [1:0] busySync_q;
	logic [1:0] accSync_q;
	logic [1:0] stopSync_q;
	logic [3:0] okSync1_q;
	logic [3:0] okSync2_q;
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			prstSync_q <= 2'h3;
			pmeSync_q <= 2'h0;
			busySync_q <= 2'h0;
			accSync_q <= 2'h0;
			stopSync_q <= 2'h0;
			okSync1_q <= 4'h0;
			okSync2_q <= 4'h0;
		end else begin
			prstSync_q <= {prstSync_q[0], pci_bus_reset_n};
			pmeSync_q <= {pmeSync_q[0], pmeEnable};
			busySync_q <= {busySync_q[0], cardBusy};
			accSync_q <= {accSync_q[0], cardAccess};
			stopSync_q <= {stopSync_q[0], pciStopRequest};
			okSync1_q <= {cardYvOk, cardXvOk, card3vOk, card5vOk};
			okSync2_q <= okSync1_q;
		end
	end
	logic busReset;
	assign busReset = !prstSync_q[1];

	// =====================================
	// avalon slave
	logic wrStrobe;
	logic rdStrobe;
	logic rdPending_q;
	logic rdCapture;
	// read side effects land on the edge that latches read data, so no event slips between
	assign rdCapture = avsRead && !rdPending_q;
	assign wrStrobe = avsWrite;
	assign rdStrobe = avsRead && rdPending_q;
	assign avsWaitRequest = avsRead && !rdPending_q;
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) rdPending_q <= 1'h0;
		else rdPending_q <= avsRead && !rdPending_q;
	end
	logic wrCtrl;
	logic wrPm;
	logic wrMask;
	logic rdPm;
	logic rdStat;
	assign wrCtrl = wrStrobe && avsAddress == `CBC_OFS_SKT_CTRL && avsByteEnable[0];
	assign wrPm = wrStrobe && avsAddress == `CBC_OFS_PWR_MGMT;
	assign wrMask = wrStrobe && avsAddress == `CBC_OFS_IRQ_MASK && avsByteEnable[0];
	assign rdPm = rdCapture && avsAddress == `CBC_OFS_PWR_MGMT;
	assign rdStat = rdCapture && avsAddress == `CBC_OFS_IRQ_STAT;

	// =====================================
	// socket control
	logic stopPolicy_q;
	cbc_pkg::cbc_supply_t vccReq_q;
	cbc_pkg::cbc_supply_t vppReq_q;
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) stopPolicy_q <= 1'h0;
		else if (wrCtrl) stopPolicy_q <= avsWriteData[`CBC_SC_STOP_BIT];
	end
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			vccReq_q <= `CBC_SUP_OFF;
			vppReq_q <= `CBC_SUP_OFF;
		end else if (busReset && !pmeSync_q[1]) begin
			vccReq_q <= `CBC_SUP_OFF;
			vppReq_q <= `CBC_SUP_OFF;
		end else if (wrCtrl) begin
			vccReq_q <= avsWriteData[`CBC_SC_VCC_LO +: 3];
			vppReq_q <= avsWriteData[`CBC_SC_VPP_LO +: 3];
		end
	end

	// =====================================
	// supply gating against card type
	function automatic logic supplyFits(input cbc_pkg::cbc_supply_t code, input logic [3:0] ok, input logic isVpp);
		unique case (code)
			`CBC_SUP_OFF: supplyFits = 1'h1;
			`CBC_VPP_12V0: supplyFits = isVpp;
			`CBC_SUP_5V0: supplyFits = ok[0];
			`CBC_SUP_3V3: supplyFits = ok[1];
			`CBC_SUP_XV: supplyFits = ok[2];
			`CBC_SUP_YV: supplyFits = ok[3];
			default: supplyFits = 1'h0;
		endcase
	endfunction
	logic vccFits;
	logic vppFits;
	assign vccFits = supplyFits(vccReq_q, okSync2_q, 1'h0);
	assign vppFits = supplyFits(vppReq_q, okSync2_q, 1'h1);
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			cardSupplyApplied <= `CBC_SUP_OFF;
			programSupplyApplied <= `CBC_SUP_OFF;
		end else begin
			cardSupplyApplied <= vccFits ? vccReq_q : `CBC_SUP_OFF;
			programSupplyApplied <= (vccFits && vppFits) ? vppReq_q : `CBC_SUP_OFF;
		end
	end

	// =====================================
	// power management
	logic ctrlEnable_q;
	logic divideSel_q;
	logic accessed_q;
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			ctrlEnable_q <= 1'h0;
			divideSel_q <= 1'h0;
		end else if (wrPm) begin
			if (avsByteEnable[2]) ctrlEnable_q <= avsWriteData[`CBC_PM_EN_BIT];
			if (avsByteEnable[0]) divideSel_q <= avsWriteData[`CBC_PM_SEL_BIT];
		end
	end
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) accessed_q <= 1'h0;
		else if (accSync_q[1]) accessed_q <= 1'h1;
		else if (rdPm) accessed_q <= 1'h0;
	end

	// =====================================
	// clock control
	cbc_pkg::cbc_clk_e clkState_q;
	logic [3:0] idleCnt_q;
	logic [3:0] divCnt_q;
	logic idleLong;
	logic stopOk;
	assign idleLong = idleCnt_q == `CBC_IDLE_CLKS;
	assign stopOk = stopPolicy_q || stopSync_q[1];
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) idleCnt_q <= 4'h0;
		else if (busySync_q[1]) idleCnt_q <= 4'h0;
		else if (!idleLong) idleCnt_q <= idleCnt_q + 4'h1;
	end
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) clkState_q <= cbc_pkg::CLK_RUN;
		else begin
			unique case (clkState_q)
				cbc_pkg::CLK_RUN: begin
					if (ctrlEnable_q && idleLong) begin
						if (divideSel_q) clkState_q <= cbc_pkg::CLK_SLOWED;
						else if (stopOk) clkState_q <= cbc_pkg::CLK_STOPPED;
					end
				end
				cbc_pkg::CLK_STOPPED: begin
					if (!ctrlEnable_q || busySync_q[1]) clkState_q <= cbc_pkg::CLK_RUN;
					else if (divideSel_q) clkState_q <= cbc_pkg::CLK_SLOWED;
				end
				cbc_pkg::CLK_SLOWED: begin
					if (!ctrlEnable_q || busySync_q[1]) clkState_q <= cbc_pkg::CLK_RUN;
					else if (!divideSel_q) clkState_q <= cbc_pkg::CLK_RUN;
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) divCnt_q <= 4'h0;
		else divCnt_q <= divCnt_q + 4'h1;
	end
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) cardClockEnable <= 1'h1;
		else begin
			unique case (clkState_q)
				cbc_pkg::CLK_RUN: cardClockEnable <= 1'h1;
				cbc_pkg::CLK_STOPPED: cardClockEnable <= 1'h0;
				cbc_pkg::CLK_SLOWED: cardClockEnable <= divCnt_q == `CBC_DIV_LAST;
			endcase
		end
	end
	logic clockChanged;
	assign clockChanged = clkState_q != cbc_pkg::CLK_RUN;

	// =====================================
	// interrupts
	logic [1:0] irqStat_q;
	logic [1:0] irqMask_q;
	logic [1:0] irqEvent;
	logic clockChangedPrev_q;
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) clockChangedPrev_q <= 1'h0;
		else clockChangedPrev_q <= clockChanged;
	end
	assign irqEvent = {clockChanged && !clockChangedPrev_q, accSync_q[1] && !accessed_q};
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) irqStat_q <= 2'h0;
		else irqStat_q <= irqEvent | (rdStat ? 2'h0 : irqStat_q);
	end
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) irqMask_q <= 2'h0;
		else if (wrMask) irqMask_q <= avsWriteData[1:0];
	end
	assign irq = |(irqStat_q & irqMask_q);

	// =====================================
	// read data
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) avsReadData <= `CBC_RESET_WORD;
		else if (rdCapture) begin
			avsReadData <= `CBC_RESET_WORD;
			unique case (avsAddress)
				`CBC_OFS_SKT_CTRL: begin
					avsReadData[`CBC_SC_STOP_BIT] <= stopPolicy_q;
					avsReadData[`CBC_SC_VCC_LO +: 3] <= vccReq_q;
					avsReadData[`CBC_SC_VPP_LO +: 3] <= vppReq_q;
				end
				`CBC_OFS_PWR_MGMT: begin
					avsReadData[`CBC_PM_ACC_BIT] <= accessed_q;
					avsReadData[`CBC_PM_SLOW_BIT] <= clockChanged;
					avsReadData[`CBC_PM_EN_BIT] <= ctrlEnable_q;
					avsReadData[`CBC_PM_SEL_BIT] <= divideSel_q;
				end
				`CBC_OFS_IRQ_STAT: avsReadData[1:0] <= irqStat_q;
				`CBC_OFS_IRQ_MASK: avsReadData[1:0] <= irqMask_q;
				default: avsReadData <= `CBC_RESET_WORD;
			endcase
		end
	end

	// =====================================
	// checks
	// running at full rate, control on, interface idle long enough
	sequence s_idle_ctrl;
		clkState_q == cbc_pkg::CLK_RUN && ctrlEnable_q && idleLong;
	endsequence
	a_access_clear: assert property (@(posedge clk_sys) disable iff (!rstN)
		rdPm && !accSync_q[1] |=> !accessed_q) else $error("access flag not cleared by read");
	a_access_set: assert property (@(posedge clk_sys) disable iff (!rstN)
		accSync_q[1] |=> accessed_q) else $error("access flag not set");
	a_clock_idle: assert property (@(posedge clk_sys) disable iff (!rstN)
		$past(clkState_q) == cbc_pkg::CLK_RUN && clkState_q != cbc_pkg::CLK_RUN |-> $past(idleLong && ctrlEnable_q))
		else $error("clock changed without idle");
	a_stop_cause: assert property (@(posedge clk_sys) disable iff (!rstN)
		$rose(clkState_q == cbc_pkg::CLK_STOPPED) |-> $past(idleLong && ctrlEnable_q && stopOk && !divideSel_q))
		else $error("clock stopped without cause");
	a_stop_policy1: assert property (@(posedge clk_sys) disable iff (!rstN)
		s_idle_ctrl ##0 (stopPolicy_q && !divideSel_q && !busySync_q[1]) |=> clkState_q == cbc_pkg::CLK_STOPPED)
		else $error("policy 1 did not stop");
	a_slow_enter: assert property (@(posedge clk_sys) disable iff (!rstN)
		s_idle_ctrl ##0 divideSel_q |=> clkState_q == cbc_pkg::CLK_SLOWED) else $error("idle clock not slowed");
	a_ctrl_off: assert property (@(posedge clk_sys) disable iff (!rstN)
		!ctrlEnable_q |=> clkState_q == cbc_pkg::CLK_RUN) else $error("clock control while disabled");
	a_full_rate: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkState_q == cbc_pkg::CLK_RUN |=> cardClockEnable) else $error("card clock not full rate");
	a_stopped_low: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkState_q == cbc_pkg::CLK_STOPPED |=> !cardClockEnable) else $error("card clock not stopped");
	a_bad_vcc: assert property (@(posedge clk_sys) disable iff (!rstN)
		!vccFits |=> cardSupplyApplied == `CBC_SUP_OFF) else $error("unfit supply applied");
	a_bus_reset: assert property (@(posedge clk_sys) disable iff (!rstN)
		busReset && !pmeSync_q[1] |=> vccReq_q == `CBC_SUP_OFF && vppReq_q == `CBC_SUP_OFF)
		else $error("bus reset left supply request");
	a_slow_flag: assert property (@(posedge clk_sys) disable iff (!rstN)
		rdStrobe && avsAddress == `CBC_OFS_PWR_MGMT |-> avsReadData[`CBC_PM_SLOW_BIT] == $past(clockChanged))
		else $error("mode flag mismatch");
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstN)
		rdStrobe |-> avsReadData[31:26] == 6'h0 && avsReadData[23:17] == 7'h0 && avsReadData[15:8] == 8'h0
		&& avsReadData[3] == 1'h0) else $error("reserved bits nonzero");
endmodule

/* File: bench/cbc_card_model.sv */
`timescale 1ns/1ps
// ==========================================
// card in the socket: activity bursts and voltage keys
module cbc_card_model (
	input wire logic clk_sys,
	input wire logic startBurst,
	input wire logic [7:0] burstLen,
	input wire logic [3:0] cardKind,
	output logic cardBusy,
	output logic cardAccess,
	output logic card5vOk,
	output logic card3vOk,
	output logic cardXvOk,
	output logic cardYvOk
);
	logic [7:0] left_q = 8'h00;
	// busy for burstLen clocks after each start
	always @(posedge clk_sys) begin
		if (startBurst)
			left_q <= burstLen;
		else if (left_q != 8'h00)
			left_q <= left_q - 8'h01;
	end
	assign cardBusy = (left_q != 8'h00);
	assign cardAccess = startBurst;
	assign {cardYvOk, cardXvOk, card3vOk, card5vOk} = cardKind;
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`include "cbc_map.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin nMismatch++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
// ==========================================
// socket clock and power bench
module testbench;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic pciBusResetN = 1'b1;
	logic pmeEnable = 1'b0;
	logic [7:0] avsAddress = 8'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0000_0000;
	logic [3:0] avsByteEnable = 4'hf;
	logic [31:0] avsReadData;
	logic [31:0] rd;
	logic avsWaitRequest, cardBusy, cardAccess, card5vOk, card3vOk, cardXvOk, cardYvOk;
	logic pciStopRequest = 1'b0;
	logic startBurst = 1'b0;
	logic [7:0] burstLen = 8'h00;
	logic [3:0] cardKind = 4'hf;
	logic cardClockEnable, irq;
	logic [2:0] cardSupplyApplied, programSupplyApplied;
	int nMismatch = 0;
	int comparisons = 0;
	int pulses;
	cbc_socket_clock_power dut (.clk_sys(clk_sys), .nrst(nrst), .pci_bus_reset_n(pciBusResetN),
		.pmeEnable(pmeEnable), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .cardBusy(cardBusy), .cardAccess(cardAccess),
		.pciStopRequest(pciStopRequest), .card5vOk(card5vOk), .card3vOk(card3vOk), .cardXvOk(cardXvOk),
		.cardYvOk(cardYvOk), .cardClockEnable(cardClockEnable), .cardSupplyApplied(cardSupplyApplied),
		.programSupplyApplied(programSupplyApplied), .irq(irq));
	cbc_card_model card (.clk_sys(clk_sys), .startBurst(startBurst), .burstLen(burstLen),
		.cardKind(cardKind), .cardBusy(cardBusy), .cardAccess(cardAccess), .card5vOk(card5vOk),
		.card3vOk(card3vOk), .cardXvOk(cardXvOk), .cardYvOk(cardYvOk));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	// ==========================================
	// bus access, waits until waitrequest is low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avsWaitRequest !== 1'b0 && n < 50);
		`CHK("waitrequest", 1'b0, avsWaitRequest)
		rd = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask
	task automatic wait_clk(input logic v);
		int n;
		n = 0;
		while (cardClockEnable !== v && n < 60) begin
			@(posedge clk_sys);
			n++;
		end
	endtask
	task automatic burst(input logic [7:0] len);
		@(posedge clk_sys);
		startBurst <= 1'b1;
		burstLen <= len;
		@(posedge clk_sys);
		startBurst <= 1'b0;
	endtask
	task automatic idle_wait;
		while (cardBusy === 1'b1) @(posedge clk_sys);
	endtask
	task report_and_stop;
		$display("mismatches %0d comparisons %0d", nMismatch, comparisons);
		if (nMismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================
	// tests
	initial begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bus(0, `CBC_OFS_SKT_CTRL, 0); `CHK("ctrl reset", 32'h0, rd)
		`CHK("vpp reset", 3'h0, programSupplyApplied)
		bus(0, `CBC_OFS_PWR_MGMT, 0); `CHK("pm reset", `CBC_RESET_WORD, rd)
		bus(0, 8'h3c, 0); `CHK("unmapped", 32'h0, rd)
		for (int i = 0; i < 8; i++) begin
			bus(1, `CBC_OFS_SKT_CTRL, {25'h0, i[2:0], 4'h0});
			repeat (3) @(posedge clk_sys);
			`CHK("vcc applied", (i >= 2 && i <= 5) ? i[2:0] : 3'h0, cardSupplyApplied)
			bus(1, `CBC_OFS_SKT_CTRL, {25'h0, `CBC_SUP_3V3, 1'b0, i[2:0]});
			repeat (3) @(posedge clk_sys);
			`CHK("vpp applied", (i <= 5) ? i[2:0] : 3'h0, programSupplyApplied)
		end
		cardKind <= 4'h2;
		bus(1, `CBC_OFS_SKT_CTRL, 32'hffff_ffdb);
		bus(0, `CBC_OFS_SKT_CTRL, 0); `CHK("ctrl bits", 32'h0000_00d3, rd)
		repeat (3) @(posedge clk_sys);
		`CHK("vcc unfit", 3'h0, cardSupplyApplied)
		pmeEnable <= 1'b1;
		bus(1, `CBC_OFS_SKT_CTRL, 32'h31);
		repeat (4) @(posedge clk_sys);
		pciBusResetN <= 1'b0;
		repeat (4) @(posedge clk_sys);
		pciBusResetN <= 1'b1;
		bus(0, `CBC_OFS_SKT_CTRL, 0); `CHK("kept by pme", 32'h31, rd)
		pmeEnable <= 1'b0;
		repeat (4) @(posedge clk_sys);
		pciBusResetN <= 1'b0;
		repeat (4) @(posedge clk_sys);
		pciBusResetN <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus(0, `CBC_OFS_SKT_CTRL, 0); `CHK("bus reset", 32'h0, rd)
		burst(8'hc8);
		bus(1, `CBC_OFS_SKT_CTRL, 32'h80);
		bus(1, `CBC_OFS_PWR_MGMT, 32'hffff_ffff);
		bus(0, `CBC_OFS_PWR_MGMT, 0); `CHK("pm bits", 32'h0001_0001, rd & 32'hfcff_ffff)
		bus(1, `CBC_OFS_PWR_MGMT, 32'h0001_0000);
		idle_wait();
		repeat (5) @(posedge clk_sys);
		`CHK("clock before idle", 1'b1, cardClockEnable)
		wait_clk(1'b0); `CHK("clock stopped", 1'b0, cardClockEnable)
		bus(0, `CBC_OFS_PWR_MGMT, 0); `CHK("mode stopped", 1'b1, rd[24])
		burst(8'h14);
		wait_clk(1'b1); `CHK("clock resumed", 1'b1, cardClockEnable)
		bus(0, `CBC_OFS_PWR_MGMT, 0); `CHK("mode normal", 1'b0, rd[24])
		`CHK("accessed", 1'b1, rd[25])
		bus(0, `CBC_OFS_PWR_MGMT, 0); `CHK("access cleared", 1'b0, rd[25])
		bus(1, `CBC_OFS_SKT_CTRL, 32'h00);
		idle_wait();
		repeat (30) @(posedge clk_sys);
		`CHK("no host stop", 1'b1, cardClockEnable)
		pciStopRequest <= 1'b1;
		wait_clk(1'b0); `CHK("host stop", 1'b0, cardClockEnable)
		bus(1, `CBC_OFS_PWR_MGMT, 32'h0001_0001);
		repeat (40) @(posedge clk_sys);
		pulses = 0;
		repeat (160) begin
			@(posedge clk_sys);
			if (cardClockEnable === 1'b1)
				pulses++;
		end
		`CHK("divide pulses", 32'h0000_000a, pulses)
		bus(0, `CBC_OFS_PWR_MGMT, 0); `CHK("mode slowed", 1'b1, rd[24])
		bus(1, `CBC_OFS_PWR_MGMT, 32'h0);
		repeat (4) @(posedge clk_sys);
		`CHK("control off", 1'b1, cardClockEnable)
		bus(1, `CBC_OFS_IRQ_MASK, 32'h1);
		bus(0, `CBC_OFS_IRQ_STAT, 0); `CHK("clock event", 1'b1, rd[1])
		burst(8'h02);
		repeat (4) @(posedge clk_sys);
		`CHK("irq raised", 1'b1, irq)
		bus(0, `CBC_OFS_IRQ_STAT, 0); `CHK("irq status", 1'b1, rd[0])
		repeat (2) @(posedge clk_sys);
		`CHK("irq cleared", 1'b0, irq)
		bus(1, `CBC_OFS_IRQ_MASK, 32'h0);
		bus(0, `CBC_OFS_PWR_MGMT, 0);
		burst(8'h02);
		repeat (4) @(posedge clk_sys);
		`CHK("irq masked", 1'b0, irq)
		bus(0, `CBC_OFS_IRQ_STAT, 0); `CHK("masked status", 1'b1, rd[0])
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		nMismatch++;
		$display("Error watchdog expected done seen hang");
		report_and_stop();
	end
endmodule
